/* File: logic/lpmc_low_power_mode_control.sv */
// Low-power mode controller: sleep/stop sequencing, wake, clock gating
//
// What this block does
// - Wait instruction, no deep stop, no return-sleep: enter sleep at once.
// - Return-sleep set, no deep stop: sleep on return from lowest handler; interrupt wakes.
// - In sleep all pins hold their run-mode state.
// - Sleep ends at once: interrupt after irq-wait, event after event-wait.
// - Stop halts all core-domain clocks and fast oscillator; contents retained.
// - Deep stop set: either wait instruction enters stop at once.
// - In stop all pins hold their run-mode state.
// - Stop entry skipped while any external line pending flag is set.
// - Leaving stop forces the fast internal oscillator as system clock.
// - Stop wakes on enabled interrupt lines or event lines, per entry kind.
// - Stop wake latency is oscillator start-up plus regulator wake delay.
// - Watchdog in stop wakes by interrupt (resume) or by reset.
// - Slow oscillator runs in stop while enabled; cleared stops the watchdog.
// - Each peripheral clock is gated by its own enable bit.
// - In sleep only the processor clock stops; peripherals keep running.
`timescale 1ns/1ps
module lpmc_low_power_mode_control
(
   input  wire logic                                   clk_sys,
   input  wire logic                                   nrst,
   input  wire lpmc_pkg::lpmc_wb_req_type              wb_req,
   output logic [31:0]                                 wb_dat_o,
   output logic                                        wb_ack_o,
   input  wire logic                                   wait_irq_instr,
   input  wire logic                                   wait_event_instr,
   input  wire logic                                   handler_return_lowest,
   input  wire logic                                   irq_request,
   input  wire logic                                   wake_event,
   input  wire logic [lpmc_pkg::NUM_EXT_LINES-1:0]     ext_line_pending,
   input  wire logic                                   ext_irq_wake,
   input  wire logic                                   ext_event_wake,
   input  wire logic                                   watchdog_irq,
   input  wire logic                                   watchdog_reset_req,
   input  wire logic                                   supply_below_level,
   output logic                                        cpu_clk_en,
   output logic                                        core_domain_clk_en,
   output logic [31:0]                                 periph_clk_en,
   output logic                                        fast_osc_en,
   output logic                                        slow_osc_en,
   output logic                                        select_fast_osc,
   output logic                                        pin_hold,
   output logic                                        core_resume,
   output logic                                        chip_reset_req,
   output logic                                        irq
);

   // Register state
   logic [31:0]               power_control;
   logic [31:0]               power_configuration;
   logic [31:0]               memory_power_control;
   logic [31:0]               periph_gate;
   logic [2:0]                lp_control;
   logic [lpmc_pkg::NUM_EVENTS-1:0] event_status;
   logic [lpmc_pkg::NUM_EVENTS-1:0] event_mask;
   logic [lpmc_pkg::NUM_EVENTS-1:0] event_set;
   lpmc_pkg::lpmc_state_type  state;
   lpmc_pkg::lpmc_state_type  next_state;
   logic                      by_event;
   logic                      next_by_event;
   logic [lpmc_pkg::WAKE_CNT_W-1:0] wake_cnt;
   logic                      wr_strobe;
   logic                      rd_strobe;
   logic [31:0]               byte_mask;
   logic [31:0]               next_rd_data;
   logic                      deep_stop_sel;
   logic                      return_sleep_sel;
   logic                      slow_osc_on;
   logic                      wait_any;
   logic                      stop_wake;
   logic                      wdg_alive_irq;
   logic                      wdg_alive_rst;

   assign deep_stop_sel    = lp_control[lpmc_pkg::BIT_DEEP_STOP];
   assign return_sleep_sel = lp_control[lpmc_pkg::BIT_RETURN_SLEEP];
   assign slow_osc_on      = lp_control[lpmc_pkg::BIT_SLOW_OSC_ON];
   assign wait_any         = wait_irq_instr | wait_event_instr;

   // Watchdog runs from the slow oscillator; cleared enable silences it
   assign wdg_alive_irq = watchdog_irq & slow_osc_on;
   assign wdg_alive_rst = watchdog_reset_req & slow_osc_on;

   // Stop wake source depends on which wait instruction entered stop
   assign stop_wake = (by_event ? ext_event_wake : ext_irq_wake)
                      | wdg_alive_irq;

   // Bus access decode: one-cycle ack, write taken with the request
   assign wr_strobe = wb_req.cyc & wb_req.stb & wb_req.we & ~wb_ack_o;
   assign rd_strobe = wb_req.cyc & wb_req.stb & ~wb_req.we & ~wb_ack_o;
   assign byte_mask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                       {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};

   // Next power state; requests sampled on the edge after the instruction
   always_comb
   begin
      next_state    = state;
      next_by_event = by_event;
      event_set     = '0;
      case (state)
         lpmc_pkg::LPMC_RUN:
         begin
            if (wait_any && deep_stop_sel)
            begin
               if (|ext_line_pending)
               begin
                  event_set[lpmc_pkg::EV_STOP_SKIPPED] = 1'b1;
               end
               else
               begin
                  next_state    = lpmc_pkg::LPMC_STOP;
                  next_by_event = wait_event_instr;
                  event_set[lpmc_pkg::EV_STOP_ENTER] = 1'b1;
               end
            end
            else if (wait_any && !return_sleep_sel)
            begin
               next_state    = lpmc_pkg::LPMC_SLEEP;
               next_by_event = wait_event_instr;
               event_set[lpmc_pkg::EV_SLEEP_ENTER] = 1'b1;
            end
            else if (handler_return_lowest && return_sleep_sel && !deep_stop_sel)
            begin
               next_state    = lpmc_pkg::LPMC_SLEEP;
               next_by_event = 1'b0;
               event_set[lpmc_pkg::EV_SLEEP_ENTER] = 1'b1;
            end
         end
         lpmc_pkg::LPMC_SLEEP:
         begin
            // Immediate exit, source chosen by entry kind
            if (by_event ? wake_event : irq_request)
            begin
               next_state = lpmc_pkg::LPMC_RUN;
            end
         end
         lpmc_pkg::LPMC_STOP:
         begin
            if (wdg_alive_rst)
            begin
               next_state = lpmc_pkg::LPMC_RUN;
            end
            else if (stop_wake)
            begin
               next_state = lpmc_pkg::LPMC_WAKE;
            end
         end
         lpmc_pkg::LPMC_WAKE:
         begin
            if (wake_cnt == lpmc_pkg::WAKE_CNT_W'(1))
            begin
               next_state = lpmc_pkg::LPMC_RUN;
               event_set[lpmc_pkg::EV_STOP_WOKE] = 1'b1;
            end
         end
         default:
         begin
            next_state = lpmc_pkg::LPMC_RUN;
         end
      endcase
   end

   // Power state register
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         state    <= lpmc_pkg::LPMC_RUN;
         by_event <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         by_event <= next_by_event;
      end
   end

   // Wake latency counter, loaded as stop is left
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         wake_cnt <= '0;
      end
      else if (state == lpmc_pkg::LPMC_STOP && next_state == lpmc_pkg::LPMC_WAKE)
      begin
         wake_cnt <= lpmc_pkg::WAKE_CNT_W'(lpmc_pkg::WAKE_CYCLES);
      end
      else if (wake_cnt != '0)
      begin
         wake_cnt <= wake_cnt - lpmc_pkg::WAKE_CNT_W'(1);
      end
   end

   // Clock and oscillator controls, all registered from the next state
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         cpu_clk_en         <= 1'b1;
         core_domain_clk_en <= 1'b1;
         fast_osc_en        <= 1'b1;
         periph_clk_en      <= lpmc_pkg::RST_PERIPH_GATE;
         pin_hold           <= 1'b0;
      end
      else
      begin
         // Only the processor clock stops in sleep
         cpu_clk_en         <= (next_state == lpmc_pkg::LPMC_RUN);
         // Core domain restarts at wake start, before the core resumes
         core_domain_clk_en <= (next_state != lpmc_pkg::LPMC_STOP);
         fast_osc_en        <= (next_state != lpmc_pkg::LPMC_STOP);
         periph_clk_en      <= (next_state == lpmc_pkg::LPMC_STOP) ? lpmc_pkg::RST_ZERO
                               : periph_gate;
         // Pins frozen in their run values while asleep or stopped
         pin_hold           <= (next_state != lpmc_pkg::LPMC_RUN);
      end
   end

   // Slow oscillator follows its enable in every mode
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         slow_osc_en <= 1'b0;
      end
      else
      begin
         slow_osc_en <= slow_osc_on;
      end
   end

   // One-cycle pulses: fast oscillator select, resume, chip reset request
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         select_fast_osc <= 1'b0;
         core_resume     <= 1'b0;
         chip_reset_req  <= 1'b0;
      end
      else
      begin
         select_fast_osc <= (state == lpmc_pkg::LPMC_WAKE)
                            && (next_state == lpmc_pkg::LPMC_RUN);
         core_resume     <= (state != lpmc_pkg::LPMC_RUN)
                            && (next_state == lpmc_pkg::LPMC_RUN);
         chip_reset_req  <= (state == lpmc_pkg::LPMC_STOP) && wdg_alive_rst;
      end
   end

   // Software registers; converter and prescaler setup stay software's job
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         power_control        <= lpmc_pkg::RST_POWER_CONTROL;
         power_configuration  <= lpmc_pkg::RST_POWER_CONFIG;
         memory_power_control <= lpmc_pkg::RST_MEM_POWER_CTRL;
         periph_gate          <= lpmc_pkg::RST_PERIPH_GATE;
         lp_control           <= '0;
         event_mask           <= '0;
      end
      else if (wr_strobe)
      begin
         case (wb_req.adr)
            lpmc_pkg::OFS_POWER_CONTROL:
            begin
               power_control <= (power_control & ~(byte_mask & lpmc_pkg::MASK_POWER_CONTROL))
                  | (wb_req.dat & byte_mask & lpmc_pkg::MASK_POWER_CONTROL);
            end
            lpmc_pkg::OFS_POWER_CONFIG:
            begin
               power_configuration <= (power_configuration
                  & ~(byte_mask & lpmc_pkg::MASK_POWER_CONFIG))
                  | (wb_req.dat & byte_mask & lpmc_pkg::MASK_POWER_CONFIG);
            end
            lpmc_pkg::OFS_MEM_POWER_CTRL:
            begin
               memory_power_control <= (memory_power_control & ~byte_mask)
                  | (wb_req.dat & byte_mask);
            end
            lpmc_pkg::OFS_PERIPH_GATE:
            begin
               periph_gate <= (periph_gate & ~byte_mask) | (wb_req.dat & byte_mask);
            end
            lpmc_pkg::OFS_LP_CONTROL:
            begin
               if (wb_req.sel[0])
               begin
                  lp_control <= wb_req.dat[2:0];
               end
            end
            lpmc_pkg::OFS_EVENT_MASK:
            begin
               if (wb_req.sel[0])
               begin
                  event_mask <= wb_req.dat[lpmc_pkg::NUM_EVENTS-1:0];
               end
            end
            default:
            begin
               lp_control <= lp_control;
            end
         endcase
      end
   end

   // Sticky events, write one to clear; a new event wins over the clear
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         event_status <= '0;
      end
      else if (wr_strobe && wb_req.adr == lpmc_pkg::OFS_EVENT_STATUS && wb_req.sel[0])
      begin
         event_status <= (event_status & ~wb_req.dat[lpmc_pkg::NUM_EVENTS-1:0])
                         | event_set;
      end
      else
      begin
         event_status <= event_status | event_set;
      end
   end

   // Level interrupt from unmasked sticky bits
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(event_status & event_mask);
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      next_rd_data = lpmc_pkg::RST_ZERO;
      case (wb_req.adr)
         lpmc_pkg::OFS_POWER_CONTROL:
         begin
            next_rd_data = power_control & lpmc_pkg::MASK_POWER_CONTROL;
         end
         lpmc_pkg::OFS_POWER_STATUS:
         begin
            // Detector output valid only while the detector is enabled
            next_rd_data[lpmc_pkg::BIT_DETECT_OUT] = supply_below_level
               & power_control[4];
         end
         lpmc_pkg::OFS_POWER_CONFIG:
         begin
            // Calibration field always reads back its default
            next_rd_data = (power_configuration & lpmc_pkg::MASK_POWER_CONFIG
               & ~lpmc_pkg::MASK_CAL_FIELD)
               | (lpmc_pkg::RST_POWER_CONFIG & lpmc_pkg::MASK_CAL_FIELD);
         end
         lpmc_pkg::OFS_MEM_POWER_CTRL:
         begin
            next_rd_data = memory_power_control;
         end
         lpmc_pkg::OFS_EVENT_STATUS:
         begin
            next_rd_data[lpmc_pkg::NUM_EVENTS-1:0] = event_status;
         end
         lpmc_pkg::OFS_EVENT_MASK:
         begin
            next_rd_data[lpmc_pkg::NUM_EVENTS-1:0] = event_mask;
         end
         lpmc_pkg::OFS_MODE_STATE:
         begin
            next_rd_data[2:0] = {by_event, state};
         end
         lpmc_pkg::OFS_PERIPH_GATE:
         begin
            next_rd_data = periph_gate;
         end
         lpmc_pkg::OFS_LP_CONTROL:
         begin
            next_rd_data[2:0] = lp_control;
         end
         default:
         begin
            next_rd_data = lpmc_pkg::RST_ZERO;
         end
      endcase
   end

   // Bus answer: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= lpmc_pkg::RST_ZERO;
      end
      else
      begin
         wb_ack_o <= wb_req.cyc & wb_req.stb & ~wb_ack_o;
         if (rd_strobe)
         begin
            wb_dat_o <= next_rd_data;
         end
      end
   end

   // Checks; a wake may follow entry at once, so entry consequents look one cycle only
   localparam int WAKE_LAT = lpmc_pkg::WAKE_CYCLES;   // Delay bounds must be local ints

   AST_SLEEP_NOW: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == lpmc_pkg::LPMC_RUN && wait_any && !deep_stop_sel && !return_sleep_sel)
      |=> state == lpmc_pkg::LPMC_SLEEP && !cpu_clk_en)
      else $error("sleep not entered after wait instruction");

   AST_SLEEP_EXIT: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == lpmc_pkg::LPMC_RUN && handler_return_lowest && return_sleep_sel
       && !deep_stop_sel && !wait_any) |=> state == lpmc_pkg::LPMC_SLEEP && !by_event)
      else $error("sleep on handler return missed");

   AST_PIN_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(state != lpmc_pkg::LPMC_RUN) |-> pin_hold)
      else $error("pins not held in low power");

   AST_SLEEP_WAKE: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == lpmc_pkg::LPMC_SLEEP && !by_event && irq_request)
      |=> state == lpmc_pkg::LPMC_RUN && cpu_clk_en)
      else $error("sleep did not end on interrupt");

   AST_STOP_CLOCKS: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == lpmc_pkg::LPMC_STOP)[*2] |-> !core_domain_clk_en && !fast_osc_en
      && periph_clk_en == lpmc_pkg::RST_ZERO)
      else $error("clocks running in stop");

   AST_STOP_SKIP: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == lpmc_pkg::LPMC_RUN && wait_any && deep_stop_sel && |ext_line_pending)
      |=> state == lpmc_pkg::LPMC_RUN && event_status[lpmc_pkg::EV_STOP_SKIPPED])
      else $error("stop entered with pending line");

   AST_STOP_ENTER: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == lpmc_pkg::LPMC_RUN && wait_any && deep_stop_sel && !(|ext_line_pending))
      |=> state == lpmc_pkg::LPMC_STOP)
      else $error("stop not entered");

   AST_FAST_OSC: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == lpmc_pkg::LPMC_WAKE && $past(state) == lpmc_pkg::LPMC_STOP)
      |-> ##[WAKE_LAT:WAKE_LAT] (select_fast_osc && core_resume))
      else $error("fast oscillator not selected after stop");

   AST_WAKE_TIME: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == lpmc_pkg::LPMC_WAKE && $past(state) == lpmc_pkg::LPMC_STOP)
      |-> !core_resume throughout (state == lpmc_pkg::LPMC_WAKE)[*8])
      else $error("core resumed before wake delay");

   AST_WDG_RESET: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == lpmc_pkg::LPMC_STOP && watchdog_reset_req && slow_osc_on)
      |=> chip_reset_req && state == lpmc_pkg::LPMC_RUN)
      else $error("watchdog reset from stop missed");

   AST_SLOW_OSC: assert property (@(posedge clk_sys) disable iff (!nrst)
      ##1 slow_osc_en == $past(slow_osc_on))
      else $error("slow oscillator enable mismatch");

   AST_SLEEP_PERIPH: assert property (@(posedge clk_sys) disable iff (!nrst)
      (state == lpmc_pkg::LPMC_SLEEP && next_state == lpmc_pkg::LPMC_SLEEP)
      |=> core_domain_clk_en && periph_clk_en == $past(periph_gate))
      else $error("peripheral clocks gated in sleep");

   COV_SLEEP: cover property (@(posedge clk_sys) disable iff (!nrst)
      state == lpmc_pkg::LPMC_SLEEP ##[1:20] state == lpmc_pkg::LPMC_RUN);
   COV_STOP_WAKE: cover property (@(posedge clk_sys) disable iff (!nrst)
      state == lpmc_pkg::LPMC_STOP ##1 state == lpmc_pkg::LPMC_WAKE);
   COV_SKIP: cover property (@(posedge clk_sys) disable iff (!nrst)
      event_set[lpmc_pkg::EV_STOP_SKIPPED]);
   COV_IRQ: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(irq));

endmodule

/* File: logic/lpmc_pkg.sv */
// Package for the low-power mode controller: map, resets, states, timing
package lpmc_pkg;
   // Register byte offsets
   localparam logic [7:0]  OFS_POWER_CONTROL   = 8'h00;
   localparam logic [7:0]  OFS_POWER_STATUS    = 8'h04;
   localparam logic [7:0]  OFS_POWER_CONFIG    = 8'h24;
   localparam logic [7:0]  OFS_MEM_POWER_CTRL  = 8'h30;
   localparam logic [7:0]  OFS_EVENT_STATUS    = 8'h40;
   localparam logic [7:0]  OFS_EVENT_MASK      = 8'h44;
   localparam logic [7:0]  OFS_MODE_STATE      = 8'h48;
   localparam logic [7:0]  OFS_PERIPH_GATE     = 8'h4C;
   localparam logic [7:0]  OFS_LP_CONTROL      = 8'h50;

   // Reset values
   localparam logic [31:0] RST_POWER_CONTROL   = 32'h0000_0600;
   localparam logic [31:0] RST_POWER_CONFIG    = 32'h0000_0160;
   localparam logic [31:0] RST_MEM_POWER_CTRL  = 32'h0000_0020;
   localparam logic [31:0] RST_PERIPH_GATE     = 32'hFFFF_FFFF;
   localparam logic [31:0] RST_ZERO            = 32'h0000_0000;

   // Writable bits and fields
   localparam logic [31:0] MASK_POWER_CONTROL  = 32'h0000_1E10;
   localparam logic [31:0] MASK_POWER_CONFIG   = 32'h0000_03FF;
   localparam logic [31:0] MASK_CAL_FIELD      = 32'h0000_03E0;
   localparam logic [31:0] MASK_ALL            = 32'hFFFF_FFFF;
   localparam int          BIT_DETECT_OUT      = 2;
   localparam int          BIT_DEEP_STOP       = 0;
   localparam int          BIT_RETURN_SLEEP    = 1;
   localparam int          BIT_SLOW_OSC_ON     = 2;

   // Event status bits
   localparam int          NUM_EVENTS          = 4;
   localparam int          EV_SLEEP_ENTER      = 0;
   localparam int          EV_STOP_ENTER       = 1;
   localparam int          EV_STOP_SKIPPED     = 2;
   localparam int          EV_STOP_WOKE        = 3;

   // Width of the external line pending vector
   localparam int          NUM_EXT_LINES       = 16;

   // Wake latency from stop: oscillator start plus regulator wake, in ns
   localparam int          CLK_MHZ             = 40;
   localparam int          FAST_OSC_START_NS   = 2000;
   localparam int          REGULATOR_WAKE_NS   = 5000;
   localparam int          WAKE_CYCLES         =
      ((FAST_OSC_START_NS + REGULATOR_WAKE_NS) * CLK_MHZ + 999) / 1000;
   localparam int          WAKE_CNT_W          = 10;

   // Power states
   typedef enum logic [1:0]
   {
      LPMC_RUN   = 2'b00,
      LPMC_SLEEP = 2'b01,
      LPMC_STOP  = 2'b10,
      LPMC_WAKE  = 2'b11
   } lpmc_state_type;

   // Wishbone request from the master
   typedef struct packed
   {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } lpmc_wb_req_type;
endpackage

/* File: verification/lpmc_core_model.sv */
// Core-side partner: wait pulses on command, wakes a halted core
`timescale 1ns/1ps
module lpmc_core_model
(
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic go_irq,
   input  wire logic go_evt,
   input  wire logic cpu_clk_en,
   output logic      wait_irq_instr,
   output logic      wait_event_instr,
   output logic      irq_request,
   output logic      wake_event
);
   logic [3:0] slept;
   // Waits are single pulses; wake only after a real stall so sleep is seen
   always_ff @(posedge clk_sys or negedge nrst)
      if (!nrst)
      begin
         wait_irq_instr <= 1'b0;
         wait_event_instr <= 1'b0;
         slept <= 4'h0;
      end
      else
      begin
         wait_irq_instr <= go_irq;
         wait_event_instr <= go_evt;
         slept <= cpu_clk_en ? 4'h0 : slept + {3'h0, slept != 4'hc};
      end
   assign irq_request = (slept == 4'hc);
   assign wake_event = irq_request;
endmodule

/* File: verification/low_power_mode_control_test.sv */
// Bench for the low-power controller: registers, sleep, stop, interrupt
`timescale 1ns/1ps
module low_power_mode_control_test;
   logic clk_sys, nrst, go_irq, go_evt, ext_event_wake, wb_ack_o, irq, pin_hold;
   logic hret, irq_wake, wdg_rst, slow_osc_en, chip_reset_req;
   logic wait_irq_instr, wait_event_instr, irq_request, wake_event;
   logic cpu_clk_en, core_domain_clk_en, fast_osc_en;
   logic [15:0] ext_line_pending;
   logic [31:0] wb_dat_o, periph_clk_en, r, seed, q[$];
   lpmc_pkg::lpmc_wb_req_type wb_req;
   int err_count, compares, cyc;
   lpmc_low_power_mode_control DUT (.clk_sys, .nrst, .wb_req, .wb_dat_o, .wb_ack_o,
      .wait_irq_instr, .wait_event_instr, .handler_return_lowest(hret), .irq_request,
      .wake_event, .ext_line_pending, .ext_irq_wake(irq_wake), .ext_event_wake,
      .watchdog_irq(1'b0), .watchdog_reset_req(wdg_rst), .supply_below_level(1'b0),
      .cpu_clk_en, .core_domain_clk_en, .periph_clk_en, .fast_osc_en, .slow_osc_en,
      .select_fast_osc(), .pin_hold, .core_resume(), .chip_reset_req, .irq);
   lpmc_core_model core (.clk_sys, .nrst, .go_irq, .go_evt, .cpu_clk_en,
      .wait_irq_instr, .wait_event_instr, .irq_request, .wake_event);
   task automatic cmp(input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic summarize();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Classic single cycle: hold until ack, release, one idle cycle
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      wb_req <= '0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task automatic wait_op(input logic evt);
      if (evt) go_evt <= 1'b1; else go_irq <= 1'b1;
      @(posedge clk_sys);
      go_irq <= 1'b0;
      go_evt <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   // Read data is taken at the ack edge against the oldest note
   always @(posedge clk_sys)
      if (wb_ack_o === 1'b1 && wb_req.we === 1'b0) cmp(q.pop_front(), wb_dat_o);
   always @(posedge clk_sys)
      if (++cyc > 6000)
      begin
         err_count++;
         summarize();
      end
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      {nrst, go_irq, go_evt, ext_event_wake, wb_req, ext_line_pending} = '0;
      {hret, irq_wake, wdg_rst} = '0;
      seed = 32'he2a5;
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      rd(lpmc_pkg::OFS_POWER_CONTROL, 32'h0000_0600);
      rd(lpmc_pkg::OFS_POWER_STATUS, 32'h0000_0000);
      rd(lpmc_pkg::OFS_POWER_CONFIG, 32'h0000_0160);
      rd(lpmc_pkg::OFS_MEM_POWER_CTRL, 32'h0000_0020);
      rd(8'h08, 32'h0000_0000);
      r = $random(seed);
      bus(1'b1, lpmc_pkg::OFS_PERIPH_GATE, r);
      rd(lpmc_pkg::OFS_PERIPH_GATE, r);
      cmp(r, periph_clk_en);
      wait_op(1'b1);
      rd(lpmc_pkg::OFS_MODE_STATE, 32'h0000_0005);
      repeat (20) @(posedge clk_sys);
      wait_op(1'b0);
      cmp(32'h0000_0005, {29'h0, core_domain_clk_en, cpu_clk_en, pin_hold});
      repeat (20) @(posedge clk_sys);
      rd(lpmc_pkg::OFS_MODE_STATE, 32'h0000_0000);
      // Return-sleep: handler return sleeps, a plain wait is ignored
      bus(1'b1, lpmc_pkg::OFS_LP_CONTROL, 32'h0000_0002);
      hret <= 1'b1;
      @(posedge clk_sys);
      hret <= 1'b0;
      rd(lpmc_pkg::OFS_MODE_STATE, 32'h0000_0001);
      repeat (20) @(posedge clk_sys);
      wait_op(1'b0);
      rd(lpmc_pkg::OFS_MODE_STATE, 32'h0000_0000);
      bus(1'b1, lpmc_pkg::OFS_LP_CONTROL, 32'h0000_0001);
      ext_line_pending <= r[15:0] | 16'h0001;
      wait_op(1'b0);
      rd(lpmc_pkg::OFS_MODE_STATE, 32'h0000_0000);
      rd(lpmc_pkg::OFS_EVENT_STATUS, 32'h0000_0005);
      cmp(32'h0000_0000, {31'h0, irq});
      bus(1'b1, lpmc_pkg::OFS_EVENT_STATUS, 32'h0000_000f);
      bus(1'b1, lpmc_pkg::OFS_EVENT_MASK, 32'h0000_0002);
      ext_line_pending <= 16'h0000;
      wait_op(1'b1); // Fast clock, no divider or converter to set up
      rd(lpmc_pkg::OFS_MODE_STATE, 32'h0000_0006);
      cmp({29'h0, fast_osc_en, core_domain_clk_en, pin_hold}, 32'h0000_0001);
      cmp(32'h0000_0001, {31'h0, irq});
      ext_event_wake <= 1'b1;
      @(posedge clk_sys);
      ext_event_wake <= 1'b0;
      rd(lpmc_pkg::OFS_MODE_STATE, 32'h0000_0007);
      repeat (290) @(posedge clk_sys);
      rd(lpmc_pkg::OFS_EVENT_STATUS, 32'h0000_000a);
      bus(1'b1, lpmc_pkg::OFS_EVENT_STATUS, 32'h0000_000f);
      cmp(32'h0000_0000, {31'h0, irq});
      // Interrupt-entered stop: line wake, then watchdog reset with slow clock on
      bus(1'b1, lpmc_pkg::OFS_LP_CONTROL, 32'h0000_0005);
      cmp(32'h0000_0001, {31'h0, slow_osc_en});
      wait_op(1'b0);
      rd(lpmc_pkg::OFS_MODE_STATE, 32'h0000_0002);
      irq_wake <= 1'b1;
      @(posedge clk_sys);
      irq_wake <= 1'b0;
      repeat (290) @(posedge clk_sys);
      rd(lpmc_pkg::OFS_MODE_STATE, 32'h0000_0000);
      wait_op(1'b0);
      wdg_rst <= 1'b1;
      @(posedge clk_sys);
      wdg_rst <= 1'b0;
      @(negedge clk_sys);
      cmp(32'h0000_0001, {31'h0, chip_reset_req});
      @(posedge clk_sys);
      rd(lpmc_pkg::OFS_MODE_STATE, 32'h0000_0000);
      summarize();
   end
endmodule
